// [src/ccsr_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ccsr_params.svh"
module ccsr_top (
   input wire logic CLK_SYS,
   input wire logic NRST,
   // cpu side write port of the condition code register
   input wire logic COND_WR,
   input wire logic [7:0] COND_WDATA,
   output logic [7:0] COND_RDATA,
   // timer control from the auxiliary control register
   input wire logic TIMER_RUN,
   input wire logic TIMER_LOAD,
   input wire logic [`CCSR_TMR_W-1:0] TIMER_LOAD_VAL,
   input wire logic TIMER_CLK_SEL,
   output logic [`CCSR_TMR_W-1:0] TIMER_COUNT,
   // remote host strobes and qualifiers
   input wire logic REMOTE_READ_STROBE,
   input wire logic REMOTE_WRITE_STROBE,
   input wire logic REMOTE_ACCESS_ENABLE,
   input wire logic REMOTE_IFACE_DMEM,
   // bidirectional interrupt pin level and instruction timing
   input wire logic BIDIR_IRQ_LEVEL,
   input wire logic INSTR_START,
   // alu result of the current instruction
   input wire logic ALU_UPDATE,
   input wire logic [1:0] ALU_OP,
   input wire logic [7:0] ALU_RESULT,
   input wire logic ALU_OVF,
   input wire logic ALU_CARRY,
   input wire logic ALU_SHIFT_OUT
);
   // trailing edge of an active-high strobe
   function automatic logic trailing(input logic prev, input logic cur);
      trailing = prev && !cur;
   endfunction : trailing

   logic rst_meta;
   logic rst_n;
   logic [7:0] condition_code_reg;
   logic rd_prev;
   logic wr_prev;
   logic run_prev;
   logic tmr_expire;
   logic [`CCSR_TMR_W-1:0] tmr_count;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // timer and its prescaler
   ccsr_timer u_timer (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .run(TIMER_RUN),
      .load(TIMER_LOAD),
      .load_val(TIMER_LOAD_VAL),
      .clk_sel(TIMER_CLK_SEL),
      .count(tmr_count),
      .expire(tmr_expire)
   );

   // instruction class decode
   ccsr_pkg::ccsr_alu_op_e alu_op;
   wire is_arith;
   wire is_logic;
   wire is_shift;
   wire alu_any;
   assign alu_op = ccsr_pkg::ccsr_alu_op_e'(ALU_OP);
   assign is_arith = ALU_UPDATE && (alu_op == ccsr_pkg::CCSR_OP_ARITH);
   assign is_logic = ALU_UPDATE && (alu_op == ccsr_pkg::CCSR_OP_LOGIC);
   assign is_shift = ALU_UPDATE && (alu_op == ccsr_pkg::CCSR_OP_SHIFT);
   assign alu_any = is_arith || is_logic || is_shift;

   // event detection; qualifiers are taken in the cycle the strobe ends
   wire remote_ok;
   wire rd_event;
   wire wr_event;
   wire run_stop;
   assign remote_ok = REMOTE_ACCESS_ENABLE && REMOTE_IFACE_DMEM;
   assign rd_event = trailing(rd_prev, REMOTE_READ_STROBE) && remote_ok;
   assign wr_event = trailing(wr_prev, REMOTE_WRITE_STROBE) && remote_ok;
   assign run_stop = trailing(run_prev, TIMER_RUN); // writing 0 to the run bit

   // software write-one-to-clear terms
   wire clr_timer;
   wire clr_rd;
   wire clr_wr;
   assign clr_timer = (COND_WR && COND_WDATA[`CCSR_BIT_TIMER]) || run_stop;
   assign clr_rd = COND_WR && COND_WDATA[`CCSR_BIT_RD];
   assign clr_wr = COND_WR && COND_WDATA[`CCSR_BIT_WR];

   // sticky flags: a set in the same cycle as a clear wins so no event is lost
   wire next_timer;
   wire next_rd;
   wire next_wr;
   assign next_timer = tmr_expire || (condition_code_reg[`CCSR_BIT_TIMER] && !clr_timer);
   assign next_rd = rd_event || (condition_code_reg[`CCSR_BIT_RD] && !clr_rd);
   assign next_wr = wr_event || (condition_code_reg[`CCSR_BIT_WR] && !clr_wr);

   // pin level only moves at instruction start; software data for this bit is dropped
   wire next_pin;
   assign next_pin = INSTR_START ? BIDIR_IRQ_LEVEL : condition_code_reg[`CCSR_BIT_PIN];

   // result flags; the alu wins over a software load in the same cycle,
   // since the instruction that updates them retires last
   wire next_neg;
   wire next_ovf;
   wire next_carry;
   wire next_zero;
   assign next_neg = alu_any ? ALU_RESULT[7] :
      (COND_WR ? COND_WDATA[`CCSR_BIT_NEG] : condition_code_reg[`CCSR_BIT_NEG]);
   assign next_ovf = is_arith ? ALU_OVF :
      (COND_WR ? COND_WDATA[`CCSR_BIT_OVF] : condition_code_reg[`CCSR_BIT_OVF]);
   assign next_carry = is_arith ? ALU_CARRY :
      (is_shift ? ALU_SHIFT_OUT :
      (COND_WR ? COND_WDATA[`CCSR_BIT_CARRY] : condition_code_reg[`CCSR_BIT_CARRY]));
   assign next_zero = alu_any ? (ALU_RESULT == 8'h00) :
      (COND_WR ? COND_WDATA[`CCSR_BIT_ZERO] : condition_code_reg[`CCSR_BIT_ZERO]);

   wire [7:0] next_cond;
   assign next_cond = {next_timer, next_rd, next_wr, next_pin,
                       next_neg, next_ovf, next_carry, next_zero};

   // the register itself; it is also the read port so reads see it directly
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         condition_code_reg <= `CCSR_RESET;
      end else begin
         condition_code_reg <= next_cond;
      end
   end

   // edge history of strobes and run bit; reset low so a low strobe at release is not an edge
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         rd_prev <= 1'b0;
         wr_prev <= 1'b0;
         run_prev <= 1'b0;
      end else begin
         rd_prev <= REMOTE_READ_STROBE;
         wr_prev <= REMOTE_WRITE_STROBE;
         run_prev <= TIMER_RUN;
      end
   end

   assign COND_RDATA = condition_code_reg;
   assign TIMER_COUNT = tmr_count;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   // each flag against its own set and clear rule, one cycle after the cause
   a_timer_set: assert property (tmr_expire |=> COND_RDATA[7])
      else $error("timer flag not set on expiry");
   a_timer_clear: assert property ((COND_WR && COND_WDATA[7] || run_stop) && !tmr_expire
      |=> !COND_RDATA[7])
      else $error("timer flag not cleared");
   a_read_set: assert property ($fell(REMOTE_READ_STROBE) && REMOTE_ACCESS_ENABLE
      && REMOTE_IFACE_DMEM |=> COND_RDATA[6])
      else $error("remote read flag not set");
   a_write_set: assert property ($fell(REMOTE_WRITE_STROBE) && remote_ok
      |=> COND_RDATA[5])
      else $error("remote write flag not set");
   a_remote_gate: assert property (!COND_RDATA[6] && !remote_ok |=> !COND_RDATA[6])
      else $error("remote read flag set while not qualified");
   a_sticky_hold: assert property (COND_RDATA[6] && !(COND_WR && COND_WDATA[6])
      |=> COND_RDATA[6])
      else $error("remote read flag dropped without a clear");
   a_sticky_only: assert property (COND_WR && COND_WDATA[6] && !COND_WDATA[5]
      && COND_RDATA[5] |=> COND_RDATA[5])
      else $error("clearing read flag disturbed write flag");
   a_pin_sample: assert property (INSTR_START |=> COND_RDATA[4] == $past(BIDIR_IRQ_LEVEL))
      else $error("pin level not sampled at instruction start");
   a_pin_readonly: assert property (!INSTR_START |=> $stable(COND_RDATA[4]))
      else $error("pin bit changed outside instruction start");
   a_neg_flag: assert property (alu_any |=> COND_RDATA[3] == $past(ALU_RESULT[7]))
      else $error("negative flag wrong");
   a_ovf_flag: assert property (is_arith |=> COND_RDATA[2] == $past(ALU_OVF))
      else $error("overflow flag wrong");
   a_carry_flag: assert property (is_arith |=> COND_RDATA[1] == $past(ALU_CARRY))
      else $error("carry flag wrong");
   a_shift_carry: assert property (is_shift |=> COND_RDATA[1] == $past(ALU_SHIFT_OUT))
      else $error("shift carry wrong");
   a_zero_flag: assert property (alu_any |=> COND_RDATA[0] == ($past(ALU_RESULT) == 8'h00))
      else $error("zero flag wrong");
   a_write_loads: assert property (COND_WR && !ALU_UPDATE
      |=> COND_RDATA[3:0] == $past(COND_WDATA[3:0]))
      else $error("software write to result flags lost");

   // nothing moves without a cause and clears take effect; these catch a stray load, a lost hold or a lost clear
   a_rd_clear: assert property (clr_rd && !rd_event |=> !COND_RDATA[6])
      else $error("remote read flag not cleared");
   a_wr_clear: assert property (clr_wr && !wr_event |=> !COND_RDATA[5])
      else $error("remote write flag not cleared");
   a_wr_hold: assert property (COND_RDATA[5] && !clr_wr |=> COND_RDATA[5])
      else $error("remote write flag dropped without a clear");
   a_timer_hold: assert property (COND_RDATA[7] && !clr_timer |=> COND_RDATA[7])
      else $error("timer flag dropped without a clear");
   a_logic_keeps: assert property (is_logic && !COND_WR |=> COND_RDATA[2:1] == $past(COND_RDATA[2:1]))
      else $error("logic instruction moved overflow or carry");
   a_shift_keeps: assert property (is_shift && !COND_WR |=> COND_RDATA[2] == $past(COND_RDATA[2]))
      else $error("shift instruction moved overflow");
   a_noop_keeps: assert property (ALU_UPDATE && alu_op == ccsr_pkg::CCSR_OP_NONE && !COND_WR
      |=> $stable(COND_RDATA[3:0]))
      else $error("update without an instruction class moved result flags");
   a_flags_hold: assert property (!ALU_UPDATE && !COND_WR |=> $stable(COND_RDATA[3:0]))
      else $error("result flags moved with no cause");
   a_pin_nowrite: assert property (COND_WR && !INSTR_START |=> $stable(COND_RDATA[4]))
      else $error("write reached the pin level bit");

   // main scenarios: expiry, remote read and clear, set against clear, shift carry
   c_timer_expiry: cover property (TIMER_RUN ##1 tmr_expire ##1 COND_RDATA[7]);
   c_remote_read: cover property (rd_event ##1 clr_rd ##1 !COND_RDATA[6]);
   c_set_clear_clash: cover property (wr_event && clr_wr);
   c_shift_carry: cover property (is_shift && ALU_SHIFT_OUT);
endmodule : ccsr_top
`default_nettype wire

// [src/ccsr_params.svh]
// Notes on behaviour
// - The timer expired flag in bit 7 is set when the running timer counts down to zero.
// - The timer expired flag is cleared by writing 1 to bit 7 or by stopping the timer with its run bit at 0.
// - The remote read flag in bit 6 is set at the end of a remote read strobe when remote access is enabled and data memory is targeted.
// - The remote write flag in bit 5 is set at the end of a remote write strobe under the same conditions.
// - The remote read and write flags stay set until software writes 1 to that bit, which clears only that flag.
// - Bit 4 is read-only and shows the level of the bidirectional interrupt pin.
// - The pin level in bit 4 is resampled once at the start of every instruction cycle.
// - Bit 3 follows the sign of the result of an arithmetic, logical or shift instruction.
// - Bit 2 goes high when an arithmetic instruction overflows.
// - Bit 1 goes high when an arithmetic instruction makes a carry or a borrow.
// - For shifts and rotates bit 1 takes the last bit shifted out of the operand.
// - Bit 0 goes high when an arithmetic, logical or shift instruction gives a zero result.
// - The timer counts down from its present value while the run bit is high and holds while it is low.
`ifndef CCSR_PARAMS_SVH
`define CCSR_PARAMS_SVH

// bit positions in the condition code register
`define CCSR_BIT_TIMER 7
`define CCSR_BIT_RD 6
`define CCSR_BIT_WR 5
`define CCSR_BIT_PIN 4
`define CCSR_BIT_NEG 3
`define CCSR_BIT_OVF 2
`define CCSR_BIT_CARRY 1
`define CCSR_BIT_ZERO 0

// reset value of the whole register
`define CCSR_RESET 8'h00

// timer width and prescaler terminal counts (cpu clock /16 and /2)
`define CCSR_TMR_W 16
`define CCSR_DIV_W 4
`define CCSR_DIV_SLOW 4'hF
`define CCSR_DIV_FAST 4'h1

`endif

// [src/ccsr_pkg.sv]
`default_nettype none
package ccsr_pkg;
   // class of the instruction that updates the result flags
   typedef enum logic [1:0] {
      CCSR_OP_NONE = 2'h0,
      CCSR_OP_ARITH = 2'h1,
      CCSR_OP_LOGIC = 2'h3,
      CCSR_OP_SHIFT = 2'h2
   } ccsr_alu_op_e;
endpackage : ccsr_pkg
`default_nettype wire

// [src/ccsr_timer.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ccsr_params.svh"
module ccsr_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic load,
   input wire logic [`CCSR_TMR_W-1:0] load_val,
   input wire logic clk_sel,
   output logic [`CCSR_TMR_W-1:0] count,
   output logic expire
);
   logic [`CCSR_DIV_W-1:0] div;
   logic [`CCSR_DIV_W-1:0] div_limit;
   logic tick;
   logic step;
   logic [`CCSR_TMR_W-1:0] next_count;

   // prescaler enable; the divider only runs with the timer so the first step is a full period
   assign div_limit = clk_sel ? `CCSR_DIV_FAST : `CCSR_DIV_SLOW;
   assign tick = run && (div >= div_limit);
   assign step = tick && (count != '0); // a timer sitting at zero does not wrap
   assign next_count = load ? load_val : (step ? count - 1'b1 : count);

   // prescaler counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= '0;
      end else if (!run || tick || load) begin
         div <= '0;
      end else begin
         div <= div + 1'b1;
      end
   end

   // count and a one-cycle pulse on reaching zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         expire <= 1'b0;
      end else begin
         count <= next_count;
         expire <= step && !load && (count == 16'h0001);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_count_halt: assert property (!run && !load |=> $stable(count))
      else $error("timer moved while halted");
   a_count_down: assert property (step && !load |=> count == $past(count) - 16'h0001)
      else $error("timer did not step down by one");
   c_expire: cover property (expire);
endmodule : ccsr_timer
`default_nettype wire

// [testbench/ccsr_remote_host.sv]
`timescale 1ns/100ps
`default_nettype none
// remote host: one strobe of len cycles per start pulse; len 1 is prompt, longer is slow
module ccsr_remote_host (
   input wire logic clk,
   input wire logic start,
   input wire logic is_wr,
   input wire logic [3:0] len,
   output logic rd_strobe,
   output logic wr_strobe,
   output logic busy
);
   logic [3:0] cnt = 4'h0;
   logic kind = 1'b0;
   // the strobe drops when the count runs out; that falling edge is the event seen by the block
   always @(posedge clk) begin
      if (start) begin
         cnt <= len;
         kind <= is_wr;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end
   // idle strobes sit low, never left at a stale level
   assign busy = (cnt != 4'h0);
   assign rd_strobe = busy & ~kind;
   assign wr_strobe = busy & kind;
endmodule : ccsr_remote_host
`default_nettype wire

// [testbench/condition_code_status_register_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module condition_code_status_register_bench;
   logic clk_sys = 1'b0, nrst = 1'b0, cond_wr = 1'b0, timer_run = 1'b0, timer_load = 1'b0, timer_clk_sel = 1'b0;
   logic ena = 1'b0, dmem = 1'b0, pin = 1'b0, instr_start = 1'b0, alu_update = 1'b0;
   logic alu_ovf = 1'b0, alu_carry = 1'b0, alu_shout = 1'b0, host_go = 1'b0, host_wr = 1'b0;
   logic [1:0] alu_op = 2'h0;
   logic [3:0] host_len = 4'h1;
   logic [7:0] cond_wdata = 8'h00, alu_result = 8'h00, cond_rdata;
   logic [15:0] timer_load_val = 16'h0000, timer_count;
   logic rd_s, wr_s, host_busy;
   int errors = 0;
   int checks_done = 0;

   ccsr_top DUT (.CLK_SYS(clk_sys), .NRST(nrst), .COND_WR(cond_wr), .COND_WDATA(cond_wdata),
      .COND_RDATA(cond_rdata), .TIMER_RUN(timer_run), .TIMER_LOAD(timer_load), .TIMER_LOAD_VAL(timer_load_val),
      .TIMER_CLK_SEL(timer_clk_sel), .TIMER_COUNT(timer_count), .REMOTE_READ_STROBE(rd_s),
      .REMOTE_WRITE_STROBE(wr_s), .REMOTE_ACCESS_ENABLE(ena), .REMOTE_IFACE_DMEM(dmem),
      .BIDIR_IRQ_LEVEL(pin), .INSTR_START(instr_start), .ALU_UPDATE(alu_update), .ALU_OP(alu_op),
      .ALU_RESULT(alu_result), .ALU_OVF(alu_ovf), .ALU_CARRY(alu_carry), .ALU_SHIFT_OUT(alu_shout));
   ccsr_remote_host host (.clk(clk_sys), .start(host_go), .is_wr(host_wr), .len(host_len),
      .rd_strobe(rd_s), .wr_strobe(wr_s), .busy(host_busy));

   // 8 ns period
   always #4 clk_sys = ~clk_sys;

   task automatic test_done;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // inputs always move 1 ns after the rising edge, clear of sampling
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] d);
      cond_wr = 1'b1;
      cond_wdata = d;
      tick(1);
      cond_wr = 1'b0;
      tick(1);
   endtask : wr

   task automatic alu(input logic [1:0] op, input logic [7:0] res, input logic [2:0] ocs, input logic [3:0] exp);
      alu_update = 1'b1;
      alu_op = op;
      alu_result = res;
      {alu_ovf, alu_carry, alu_shout} = ocs;
      tick(1);
      alu_update = 1'b0;
      tick(1);
      check({12'h000, cond_rdata[3:0]}, {12'h000, exp});
   endtask : alu

   // bounded wait: a hang counts as a mismatch and ends the run
   task automatic remote(input logic w, input logic [3:0] len);
      int i;
      host_go = 1'b1;
      host_wr = w;
      host_len = len;
      tick(1);
      host_go = 1'b0;
      for (i = 0; i < 20 && host_busy; i++) tick(1);
      if (host_busy) begin
         errors++;
         test_done();
      end
      tick(2);
   endtask : remote

   task automatic wait_expire;
      int i;
      for (i = 0; i < 40 && cond_rdata[7] !== 1'b1; i++) tick(1);
      if (cond_rdata[7] !== 1'b1) begin
         errors++;
         test_done();
      end
   endtask : wait_expire

   task automatic s_timer;
      timer_clk_sel = 1'b1;
      timer_load_val = 16'h0002;
      timer_load = 1'b1;
      tick(1);
      timer_load = 1'b0;
      timer_run = 1'b1;
      wait_expire();
      check(timer_count, 16'h0000);
      tick(20);
      check({8'h00, cond_rdata}, 16'h0080);
      wr(8'h80);
      check({8'h00, cond_rdata}, 16'h0000);
      timer_load = 1'b1;
      tick(1);
      timer_load = 1'b0;
      wait_expire();
      check({8'h00, cond_rdata}, 16'h0080);
      timer_run = 1'b0;
      tick(2);
      check({8'h00, cond_rdata}, 16'h0000);
      // slow clock: two steps in 42 cycles, then the count must freeze
      timer_clk_sel = 1'b0;
      timer_load_val = 16'h0100;
      timer_load = 1'b1;
      tick(1);
      timer_load = 1'b0;
      timer_run = 1'b1;
      tick(40);
      timer_run = 1'b0;
      tick(2);
      check(timer_count, 16'h00FE);
      tick(40);
      check(timer_count, 16'h00FE);
   endtask : s_timer

   task automatic s_pin;
      pin = 1'b1;
      tick(3);
      check({15'h0000, cond_rdata[4]}, 16'h0000);
      instr_start = 1'b1;
      tick(1);
      instr_start = 1'b0;
      pin = 1'b0;
      tick(2);
      check({15'h0000, cond_rdata[4]}, 16'h0001);
      wr(8'h00);
      check({15'h0000, cond_rdata[4]}, 16'h0001);
      instr_start = 1'b1;
      tick(1);
      instr_start = 1'b0;
      tick(1);
      check({15'h0000, cond_rdata[4]}, 16'h0000);
   endtask : s_pin

   task automatic s_remote;
      ena = 1'b1;
      dmem = 1'b1;
      remote(1'b0, 4'h1);
      check({14'h0000, cond_rdata[6:5]}, 16'h0002);
      remote(1'b1, 4'h8);
      check({14'h0000, cond_rdata[6:5]}, 16'h0003);
      wr(8'h40);
      check({14'h0000, cond_rdata[6:5]}, 16'h0001);
      ena = 1'b0;
      remote(1'b0, 4'h3);
      check({14'h0000, cond_rdata[6:5]}, 16'h0001);
      ena = 1'b1;
      dmem = 1'b0;
      remote(1'b0, 4'h3);
      check({14'h0000, cond_rdata[6:5]}, 16'h0001);
      wr(8'h20);
      check({14'h0000, cond_rdata[6:5]}, 16'h0000);
   endtask : s_remote

   task automatic s_alu;
      alu(ccsr_pkg::CCSR_OP_ARITH, 8'h80, 3'b110, 4'hE);
      alu(ccsr_pkg::CCSR_OP_ARITH, 8'h00, 3'b000, 4'h1);
      alu(ccsr_pkg::CCSR_OP_ARITH, 8'h01, 3'b110, 4'h6);
      alu(ccsr_pkg::CCSR_OP_LOGIC, 8'h80, 3'b000, 4'hE);
      alu(ccsr_pkg::CCSR_OP_LOGIC, 8'h00, 3'b000, 4'h7);
      alu(ccsr_pkg::CCSR_OP_SHIFT, 8'h00, 3'b001, 4'h7);
      alu(ccsr_pkg::CCSR_OP_SHIFT, 8'h81, 3'b000, 4'hC);
      alu(ccsr_pkg::CCSR_OP_NONE, 8'h00, 3'b111, 4'hC);
      wr(8'h05);
      check({8'h00, cond_rdata}, 16'h0005);
   endtask : s_alu

   // reset held for 3 cycles, first request 3 edges after release
   initial begin
      tick(3);
      nrst = 1'b1;
      tick(3);
      check({8'h00, cond_rdata}, 16'h0000);
      s_timer();
      s_pin();
      s_remote();
      s_alu();
      test_done();
   end
endmodule : condition_code_status_register_bench
`default_nettype wire
